//--- flash_prot_pkg.sv
// Shared constants and types for the flash protection controller
`default_nettype none
package flash_prot_pkg;

	// ****************************************
	// Clock and times
	// ****************************************
	localparam int CLOCK_NS = 100;
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 200;
	localparam int T_HV_SETUP_NS = 4000;
	localparam int T_WE_PULSE_NS = 200;
	localparam int T_ACCESS_NS = 200;
	localparam int T_PROT_PULSE_NS = 150000;
	localparam int T_UNPROT_PULSE_NS = 15000000;
	localparam int SYNC_STAGES = 3;

	localparam logic [17:0] CYC_RP = 18'((T_RP_NS + CLOCK_NS - 1) / CLOCK_NS);
	localparam logic [17:0] CYC_RH = 18'((T_RH_NS + CLOCK_NS - 1) / CLOCK_NS);
	localparam logic [17:0] CYC_HV_SETUP = 18'((T_HV_SETUP_NS + CLOCK_NS - 1) / CLOCK_NS);
	localparam logic [17:0] CYC_PROT_PULSE = 18'((T_PROT_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS);
	localparam int CYC_UNPROT_DEFAULT = (T_UNPROT_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam logic [7:0] CYC_WE = 8'((T_WE_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS);
	localparam logic [7:0] CYC_READ = 8'((T_ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS + SYNC_STAGES);

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_RDATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_A9_METHOD = 3;
	localparam int CTRL_SECURE_LOCK = 4;
	localparam int CTRL_ALL_PROT = 5;
	localparam int CTRL_TEMP_UNPROT = 6;
	localparam int CTRL_BOOT_GUARD = 7;
	localparam int CTRL_GO = 8;

	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_VERIFIED = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_REPROTECT = 4;
	localparam int ST_LOCK_IND = 5;

	localparam logic [20:0] ADDR_RESET = 21'h000000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		OP_READ = 3'b000,
		OP_WRITE = 3'b001,
		OP_PROTECT = 3'b010,
		OP_UNPROTECT = 3'b011,
		OP_RESET = 3'b100
	} op_t;

	typedef enum logic [3:0] {
		M_RST_LOW = 4'b0000,
		M_RST_HIGH = 4'b0001,
		M_IDLE = 4'b0010,
		M_HV_SETUP = 4'b0011,
		M_CMD = 4'b0100,
		M_CMD_WAIT = 4'b0101,
		M_PULSE = 4'b0110,
		M_VERIFY = 4'b0111,
		M_VERIFY_WAIT = 4'b1000,
		M_HV_DOWN = 4'b1001,
		M_ACCESS = 4'b1010,
		M_ACCESS_WAIT = 4'b1011
	} main_state_t;

	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_SETUP = 2'b01,
		E_STROBE = 2'b10,
		E_HOLD = 2'b11
	} eng_state_t;

endpackage
`default_nettype wire

//--- flash_bus_cycle.sv
// One asynchronous flash read or write bus cycle
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
	import flash_prot_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic start,
	input wire logic write,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic dq_oe,
	output logic sample,
	output logic done
);
	import flash_prot_pkg::*;

	typedef struct packed {
		eng_state_t state;
		logic [7:0] cnt;
		logic write;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic dq_oe;
		logic sample;
		logic done;
	} eng_t;

	eng_t r_reg;
	eng_t r_next;

	always_comb
	begin
		r_next = r_reg;
		r_next.sample = 1'b0;
		r_next.done = 1'b0;
		unique case (r_reg.state)
			E_IDLE:
			begin
				if (start)
				begin
					r_next.write = write;
					r_next.ce_n = 1'b0;
					r_next.dq_oe = write;
					r_next.state = E_SETUP;
				end
			end
			E_SETUP:
			begin
				r_next.we_n = ~r_reg.write;
				r_next.oe_n = r_reg.write;
				r_next.cnt = r_reg.write ? CYC_WE : CYC_READ;
				r_next.state = E_STROBE;
			end
			E_STROBE:
			begin
				// Read data is taken only after the pin synchroniser has settled
				if (r_reg.cnt == 8'h01)
				begin
					r_next.sample = ~r_reg.write;
					r_next.we_n = 1'b1;
					r_next.oe_n = 1'b1;
					r_next.state = E_HOLD;
				end
				else
				begin
					r_next.cnt = r_reg.cnt - 8'h01;
				end
			end
			E_HOLD:
			begin
				r_next.ce_n = 1'b1;
				r_next.dq_oe = 1'b0;
				r_next.done = 1'b1;
				r_next.state = E_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			r_reg <= '{state: E_IDLE, cnt: 8'h00, write: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, dq_oe: 1'b0, sample: 1'b0, done: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign ce_n = r_reg.ce_n;
	assign oe_n = r_reg.oe_n;
	assign we_n = r_reg.we_n;
	assign dq_oe = r_reg.dq_oe;
	assign sample = r_reg.sample;
	assign done = r_reg.done;

endmodule // flash_bus_cycle
`default_nettype wire

//--- flash_sector_protection_control.sv
// Host controller driving flash protection, reset and bus cycles, commanded over APB
// Operation
// - Flash reset pulse returns the part to array read for boot fetch.
// - In-system protect: reset at high voltage, A6 low, A1 high, A0 low.
// - Alternate protect: high voltage on A9 and output enable, same address bits.
// - Every protect is followed by a protect verification read.
// - Unprotect only after software confirms every group is protected first.
// - After unprotect, groups meant to stay protected must be re-protected.
// - In-system unprotect: reset at high voltage, A6 high, A1 high, A0 low.
// - Alternate unprotect: high voltage on A9 and output enable, A6 high.
// - Security lock: enter sequence then protect, reset may stay normal; the code sends no enter sequence, just the protect write.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module flash_sector_protection_control
	import flash_prot_pkg::*;
#(
	parameter int UNPROT_PULSE_CYCLES = CYC_UNPROT_DEFAULT
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [20:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_reset_n,
	output logic reset_high_voltage_level,
	output logic address_bit_nine_high_voltage_level,
	output logic oe_high_voltage_level,
	output logic boot_guard_accel_pin
);
	import flash_prot_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		main_state_t state;
		logic [17:0] cnt;
		op_t op;
		logic a9_method;
		logic secure_lock;
		logic all_prot;
		logic temp_unprot;
		logic boot_guard;
		logic [20:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic done;
		logic verified;
		logic refused;
		logic reprotect;
		logic rst_n;
		logic reset_hv;
		logic a9_hv;
		logic oe_hv;
		logic [20:0] addr_out;
		logic [15:0] dq_out;
		logic eng_start;
		logic eng_write;
		logic [15:0] sync1;
		logic [15:0] sync2;
		logic [15:0] sync3;
		logic [31:0] prdata;
		logic pslverr;
	} ctl_t;

	ctl_t r;
	ctl_t n;
	logic eng_sample;
	logic eng_done;
	logic setup_phase;
	logic wr_access;
	logic mapped;
	logic [7:0] ofs;
	logic [31:0] status_word;
	logic go;
	logic prot_op;

	assign setup_phase = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign ofs = paddr[7:0];
	assign mapped = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'b00) & (ofs <= OFS_STATUS);
	assign go = wr_access & mapped & (ofs == OFS_CTRL) & pwdata[CTRL_GO];
	assign prot_op = (r.op == OP_PROTECT);
	assign status_word = {26'h0000000, r.rdata[7], r.reprotect, r.refused, r.verified, r.done,
		(r.state != M_IDLE)};

	flash_bus_cycle u_cycle (
		.clock(clock),
		.resetn(resetn),
		.start(r.eng_start),
		.write(r.eng_write),
		.ce_n(flash_ce_n),
		.oe_n(flash_oe_n),
		.we_n(flash_we_n),
		.dq_oe(flash_dq_oe),
		.sample(eng_sample),
		.done(eng_done)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		n = r;
		n.eng_start = 1'b0;
		n.sync1 = flash_dq_in;
		n.sync2 = r.sync1;
		n.sync3 = r.sync2;

		// APB register side; read data latched in the setup cycle
		if (setup_phase)
		begin
			n.pslverr = ~mapped;
			n.prdata = 32'h00000000;
			if (ofs == OFS_CTRL)
				n.prdata = {24'h000000, r.boot_guard, r.temp_unprot, r.all_prot,
					r.secure_lock, r.a9_method, r.op};
			else if (ofs == OFS_ADDR)
				n.prdata = {11'h000, r.addr};
			else if (ofs == OFS_WDATA)
				n.prdata = {16'h0000, r.wdata};
			else if (ofs == OFS_RDATA)
				n.prdata = {16'h0000, r.rdata};
			else if (ofs == OFS_STATUS)
				n.prdata = status_word;
		end
		if (wr_access && mapped)
		begin
			if (ofs == OFS_CTRL)
			begin
				n.temp_unprot = pwdata[CTRL_TEMP_UNPROT];
				n.boot_guard = pwdata[CTRL_BOOT_GUARD];
				if (r.state == M_IDLE)
				begin
					n.op = op_t'(pwdata[CTRL_OP_LSB +: 3]);
					n.a9_method = pwdata[CTRL_A9_METHOD];
					n.secure_lock = pwdata[CTRL_SECURE_LOCK];
					n.all_prot = pwdata[CTRL_ALL_PROT];
				end
			end
			else if (ofs == OFS_ADDR && r.state == M_IDLE)
				n.addr = pwdata[20:0];
			else if (ofs == OFS_WDATA && r.state == M_IDLE)
				n.wdata = pwdata[15:0];
			else if (ofs == OFS_STATUS)
			begin
				// Write one to clear; the hardware set below wins
				if (pwdata[ST_DONE])
					n.done = 1'b0;
				if (pwdata[ST_REFUSED])
					n.refused = 1'b0;
				if (pwdata[ST_REPROTECT])
					n.reprotect = 1'b0;
			end
		end

		unique case (r.state)
			M_RST_LOW:
			begin
				n.rst_n = 1'b0;
				n.reset_hv = 1'b0;
				if (r.cnt == 18'h00001)
				begin
					n.rst_n = 1'b1;
					n.cnt = CYC_RH;
					n.state = M_RST_HIGH;
				end
				else
					n.cnt = r.cnt - 18'h00001;
			end
			M_RST_HIGH:
			begin
				if (r.cnt == 18'h00001)
				begin
					n.done = 1'b1;
					n.state = M_IDLE;
				end
				else
					n.cnt = r.cnt - 18'h00001;
			end
			M_IDLE:
			begin
				// Temporary unprotect rides on the reset qualifier between operations
				n.reset_hv = r.temp_unprot;
				if (go)
				begin
					n.addr_out = r.addr;
					n.dq_out = r.wdata;
					unique case (n.op)
						OP_READ, OP_WRITE:
							n.state = M_ACCESS;
						OP_RESET:
						begin
							n.rst_n = 1'b0;
							n.cnt = CYC_RP;
							n.state = M_RST_LOW;
						end
						OP_PROTECT, OP_UNPROTECT:
						begin
							if (n.op == OP_UNPROTECT && !n.all_prot)
								n.refused = 1'b1;
							else
							begin
								n.verified = 1'b0; // Stale result must not stand for this run
								// Group select plus A6 choosing protect or unprotect
								n.addr_out = {r.addr[20:7], (n.op == OP_UNPROTECT),
									r.addr[5:2], 2'b10};
								n.reset_hv = ~n.secure_lock & ~n.a9_method;
								n.a9_hv = ~n.secure_lock & n.a9_method;
								n.oe_hv = ~n.secure_lock & n.a9_method;
								n.cnt = CYC_HV_SETUP;
								n.state = M_HV_SETUP;
							end
						end
						default:
							n.refused = 1'b1;
					endcase
				end
			end
			M_HV_SETUP:
			begin
				if (r.cnt == 18'h00001)
					n.state = M_CMD;
				else
					n.cnt = r.cnt - 18'h00001;
			end
			M_CMD:
			begin
				n.eng_start = 1'b1;
				n.eng_write = 1'b1;
				n.state = M_CMD_WAIT;
			end
			M_CMD_WAIT:
			begin
				if (eng_done)
				begin
					n.cnt = prot_op ? CYC_PROT_PULSE : 18'(UNPROT_PULSE_CYCLES);
					n.state = M_PULSE;
				end
			end
			M_PULSE:
			begin
				if (r.cnt == 18'h00001)
				begin
					n.oe_hv = 1'b0; // Verify read needs a real low on output enable
					n.state = M_VERIFY;
				end
				else
					n.cnt = r.cnt - 18'h00001;
			end
			M_VERIFY:
			begin
				n.eng_start = 1'b1;
				n.eng_write = 1'b0;
				n.state = M_VERIFY_WAIT;
			end
			M_VERIFY_WAIT:
			begin
				if (eng_sample)
				begin
					n.rdata = r.sync3;
					n.verified = prot_op ? r.sync3[0] : ~r.sync3[0];
				end
				if (eng_done)
				begin
					n.reset_hv = 1'b0;
					n.a9_hv = 1'b0;
					n.cnt = CYC_HV_SETUP;
					n.state = M_HV_DOWN;
				end
			end
			M_HV_DOWN:
			begin
				if (r.cnt == 18'h00001)
				begin
					n.done = 1'b1;
					if (!prot_op)
						n.reprotect = 1'b1;
					n.state = M_IDLE;
				end
				else
					n.cnt = r.cnt - 18'h00001;
			end
			M_ACCESS:
			begin
				n.eng_start = 1'b1;
				n.eng_write = (r.op == OP_WRITE);
				n.state = M_ACCESS_WAIT;
			end
			M_ACCESS_WAIT:
			begin
				if (eng_sample)
					n.rdata = r.sync3; // Bit seven carries the lock indicator in autoselect
				if (eng_done)
				begin
					n.done = 1'b1;
					n.state = M_IDLE;
				end
			end
			default:
				n.state = M_IDLE;
		endcase

		if (go && r.state != M_IDLE)
			n.refused = 1'b1;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			// Flash is held in reset with the controller and then released
			r <= '{state: M_RST_LOW, cnt: CYC_RP, op: OP_READ, addr: ADDR_RESET,
				wdata: DATA_RESET, rdata: DATA_RESET, addr_out: ADDR_RESET,
				dq_out: DATA_RESET, sync1: DATA_RESET, sync2: DATA_RESET,
				sync3: DATA_RESET, prdata: 32'h00000000, default: 1'b0};
		end
		else
		begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = r.pslverr;
	assign flash_addr = r.addr_out;
	assign flash_dq_out = r.dq_out;
	assign flash_reset_n = r.rst_n;
	assign reset_high_voltage_level = r.reset_hv;
	assign address_bit_nine_high_voltage_level = r.a9_hv;
	assign oe_high_voltage_level = r.oe_hv;
	assign boot_guard_accel_pin = r.boot_guard;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_reset_pulse_width: assert property ((r.state == M_IDLE) && (n.state == M_RST_LOW)
		|=> (!flash_reset_n) [*5] ##1 flash_reset_n)
		else $error("flash reset pulse width wrong");
	a_prot_pins_insys: assert property ((!flash_we_n && prot_op && !r.a9_method && !r.secure_lock)
		|-> reset_high_voltage_level && flash_reset_n && !flash_addr[6] && flash_addr[1]
		&& !flash_addr[0])
		else $error("in-system protect pins wrong");
	a_prot_pins_a9: assert property ((!flash_we_n && prot_op && r.a9_method && !r.secure_lock)
		|-> address_bit_nine_high_voltage_level && oe_high_voltage_level
		&& !reset_high_voltage_level && !flash_addr[6] && flash_addr[1] && !flash_addr[0])
		else $error("high-voltage protect pins wrong");
	a_verify_follows: assert property ((r.state == M_PULSE) && (r.cnt == 18'h00001)
		|=> ##[1:8] !flash_oe_n)
		else $error("no verify read after pulse");
	a_unprot_confirm: assert property ((r.state == M_IDLE) && (n.state == M_HV_SETUP)
		&& (n.op == OP_UNPROTECT) |-> n.all_prot)
		else $error("unprotect started without confirmation");
	a_reprotect_flag: assert property ((r.state == M_HV_DOWN) && (r.op == OP_UNPROTECT)
		&& (r.cnt == 18'h00001) |=> r.reprotect [*2])
		else $error("reprotect flag not raised");
	a_unprot_pins_insys: assert property ((!flash_we_n && r.op == OP_UNPROTECT && !r.a9_method)
		|-> reset_high_voltage_level && flash_addr[6] && flash_addr[1] && !flash_addr[0])
		else $error("in-system unprotect pins wrong");
	a_unprot_pins_a9: assert property ((!flash_we_n && r.op == OP_UNPROTECT && r.a9_method)
		|-> address_bit_nine_high_voltage_level && oe_high_voltage_level && flash_addr[6])
		else $error("high-voltage unprotect pins wrong");
	a_secure_lock_pins: assert property ((!flash_we_n && prot_op && r.secure_lock)
		|-> flash_reset_n && !reset_high_voltage_level && !address_bit_nine_high_voltage_level)
		else $error("security lock drove high voltage");

endmodule // flash_sector_protection_control
`default_nettype wire

//--- flash_device_model.sv
// Behavioural flash part: group protection, temporary unprotect, boot guard
`timescale 1ns/100ps
`default_nettype none
module flash_device_model
(
	input wire logic [20:0] addr,
	input wire logic [15:0] dq_wr,
	input wire logic dq_drive,
	output logic [15:0] dq_rd,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic reset_hv,
	input wire logic a9_hv,
	input wire logic oe_hv,
	input wire logic boot_guard
);
	// ****************************************
	// Protection state and array
	// ****************************************
	logic [7:0] prot_reg;
	logic [15:0] mem [8];
	logic [15:0] out_val;
	logic [15:0] hold_val;
	logic [2:0] grp;
	logic hv_cmd;
	logic blocked;
	logic drive;
	// One bit covers a whole group of adjacent sectors
	assign grp = addr[20:18];
	// High voltage is a qualifier per pin
	assign hv_cmd = (reset_hv | (a9_hv & oe_hv)) & (addr[1:0] == 2'b10);
	assign blocked = (prot_reg[grp] & !reset_hv) | (!boot_guard & (addr[20:13] == 8'h00));
	assign drive = !ce_n & !oe_n & reset_n & !dq_drive;
	assign out_val = ((reset_hv | a9_hv) & (addr[1:0] == 2'b10)) ? {15'h0000, prot_reg[grp]}
		: mem[grp];
	// Released bus shows the inverse so no stale value passes for data
	assign dq_rd = drive ? out_val : ~hold_val;
	initial
	begin
		prot_reg = 8'h00;
		hold_val = 16'h0000;
		for (int k = 0; k < 8; k++)
			mem[k] = 16'hffff;
	end
	always @(out_val or drive)
		if (drive)
			hold_val = out_val;
	// ****************************************
	// Write cycles take effect on the rising write strobe
	// ****************************************
	always @(posedge we_n)
		if (!ce_n & reset_n)
		begin
			if (hv_cmd & !addr[6])
				prot_reg[grp] <= 1'b1;
			else if (hv_cmd)
				prot_reg <= 8'h00; // All groups at once
			else if (!blocked)
				mem[grp] <= dq_wr;
		end
endmodule // flash_device_model
`default_nettype wire

//--- test_flash_sector_protection_control.sv
// Self-checking bench for the flash protection controller with a flash model
`timescale 1ns/100ps
`default_nettype none
module test_flash_sector_protection_control;
	import flash_prot_pkg::*;
	typedef struct packed {
		logic [11:0] ctrl;
		logic [20:0] addr;
		logic [15:0] wdata;
		logic [7:0] ofs;
		logic [15:0] mask;
		logic [15:0] exp;
	} row_t;
	logic clock, resetn, psel, penable, pwrite, pready, pslverr, dq_oe, ce_n, oe_n, we_n;
	logic frst_n, rst_hv, a9_hv, oe_hv, guard;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [20:0] flash_addr;
	logic [15:0] dq_out, dq_in;
	int n_errors = 0;
	int n_compared = 0;
	int low_cnt = 0;
	int low_before;
	// ****************************************
	// Table: control word, address, data, register, mask, expected
	// ****************************************
	row_t rows [22] = '{
		'{12'h181, 21'h040000, 16'h1234, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h180, 21'h040000, 16'h0000, OFS_RDATA, 16'hffff, 16'h1234},
		'{12'h182, 21'h040000, 16'h0000, OFS_STATUS, 16'h0004, 16'h0004},
		'{12'h181, 21'h040000, 16'h5678, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h180, 21'h040000, 16'h0000, OFS_RDATA, 16'hffff, 16'h1234},
		'{12'h1c1, 21'h040000, 16'h5678, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h1c0, 21'h040000, 16'h0000, OFS_RDATA, 16'hffff, 16'h5678},
		'{12'h181, 21'h040000, 16'h9abc, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h180, 21'h040000, 16'h0000, OFS_RDATA, 16'hffff, 16'h5678},
		'{12'h183, 21'h040000, 16'h0000, OFS_STATUS, 16'h0008, 16'h0008},
		'{12'h1a3, 21'h040000, 16'h0000, OFS_STATUS, 16'h0014, 16'h0014},
		'{12'h181, 21'h040000, 16'h9abc, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h180, 21'h040000, 16'h0000, OFS_RDATA, 16'hffff, 16'h9abc},
		'{12'h101, 21'h000000, 16'h1111, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h100, 21'h000000, 16'h0000, OFS_RDATA, 16'hffff, 16'hffff},
		'{12'h141, 21'h000000, 16'h3333, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h140, 21'h000000, 16'h0000, OFS_RDATA, 16'hffff, 16'hffff},
		'{12'h181, 21'h000000, 16'h2222, OFS_STATUS, 16'h0002, 16'h0002},
		'{12'h180, 21'h000000, 16'h0000, OFS_RDATA, 16'hffff, 16'h2222},
		'{12'h18a, 21'h080000, 16'h0000, OFS_STATUS, 16'h0004, 16'h0004},
		'{12'h1ab, 21'h080000, 16'h0000, OFS_STATUS, 16'h0004, 16'h0004},
		'{12'h192, 21'h0c0000, 16'h0080, OFS_STATUS, 16'h0022, 16'h0022}
	};
	flash_sector_protection_control #(.UNPROT_PULSE_CYCLES(20)) i_dut (.clock(clock),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_reset_n(frst_n), .reset_high_voltage_level(rst_hv),
		.address_bit_nine_high_voltage_level(a9_hv), .oe_high_voltage_level(oe_hv),
		.boot_guard_accel_pin(guard));
	flash_device_model i_flash (.addr(flash_addr), .dq_wr(dq_out), .dq_drive(dq_oe),
		.dq_rd(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(frst_n),
		.reset_hv(rst_hv), .a9_hv(a9_hv), .oe_hv(oe_hv), .boot_guard(guard));
	// ****************************************
	// Clock, pulse counter, tasks
	// ****************************************
	initial
		clock = 1'b0;
	always #50 clock = ~clock;
	always @(posedge clock)
		if (resetn && frst_n === 1'b0)
			low_cnt++;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Polls status; the count bounds the wait beside the watchdog
	task automatic wait_idle();
		logic [31:0] s;
		int k;
		k = 0;
		repeat (2) @(posedge clock);
		do
		begin
			apb(1'b0, {24'h000000, OFS_STATUS}, 32'h0, s);
			k++;
		end
		while (s[ST_BUSY] !== 1'b0 && k < 3000);
		check("busy", {31'h0, s[ST_BUSY]}, 32'h0);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clock);
		n_errors++;
		complete_run();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		resetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (10) @(posedge clock);
		check("pins in reset", {frst_n, ce_n, we_n, rst_hv, a9_hv, oe_hv, guard}, 32'h30);
		resetn <= 1'b1;
		wait_idle();
		check("reset pulse", low_cnt, CYC_RP);
		$display("reset test done");
		for (int i = 0; i < 22; i++)
		begin
			apb(1'b1, {24'h000000, OFS_ADDR}, {11'h0, rows[i].addr}, r);
			apb(1'b1, {24'h000000, OFS_WDATA}, {16'h0, rows[i].wdata}, r);
			apb(1'b1, {24'h000000, OFS_STATUS}, 32'h0000001a, r);
			// Mode bits settle before go, so the part sees them for the whole cycle
			apb(1'b1, {24'h000000, OFS_CTRL}, {20'h0, rows[i].ctrl & 12'h0ff}, r);
			apb(1'b1, {24'h000000, OFS_CTRL}, {20'h0, rows[i].ctrl}, r);
			wait_idle();
			apb(1'b0, {24'h000000, rows[i].ofs}, 32'h0, r);
			check($sformatf("row %0d", i), r & {16'h0, rows[i].mask}, {16'h0, rows[i].exp});
			$display("row %0d done", i);
		end
		low_before = low_cnt;
		apb(1'b1, {24'h000000, OFS_STATUS}, 32'h0000001a, r);
		apb(1'b1, {24'h000000, OFS_CTRL}, 32'h184, r);
		apb(1'b1, {24'h000000, OFS_CTRL}, 32'h184, r);
		wait_idle();
		check("reset op pulse", low_cnt - low_before, CYC_RP);
		apb(1'b0, {24'h000000, OFS_STATUS}, 32'h0, r);
		check("go while busy", r & 32'h0000000a, 32'h0000000a);
		$display("reset op test done");
		apb(1'b0, 32'h14, 32'h0, r);
		check("unmapped data", r, 32'h0);
		check("unmapped error", {31'h0, pslverr}, 32'h1);
		$display("unmapped test done");
		complete_run();
	end
endmodule // test_flash_sector_protection_control
`default_nettype wire
